/* File: shared/adc_ctl_regs.vh */
// register map and timing constants for the converter control block
// assumes: included by the decoder and the control design files of the block, by bare name
`ifndef ADC_CTL_REGS_VH
`define ADC_CTL_REGS_VH

`define CTL1_ADDR 8'h08
`define SPT_HI_ADDR 8'h0C
`define SPT_LO_ADDR 8'h10
`define STATUS_ADDR 8'h14

`define CTL1_POWER_BIT 0
`define CTL1_REPEAT_BIT 1
`define CTL1_CAL_BIT 2
`define CTL1_REINIT_BIT 3
`define CTL1_MASK 32'h0000000F

`define STATUS_AWAKE_BIT 0
`define STATUS_BUSY_BIT 1

`define SPT_HI_MASK 32'h00FFFFFF
`define SPT_LO_MASK 32'h3FFFFFFF
`define REG_RESET 32'h00000000

`define SPT_FIELD_W 3
`define SPT_HI_FIELDS 8
`define SPT_LO_FIELDS 10
`define CH_HI_FIRST 10
`define CH_EXTRA 18

// sample durations in half cycles: 1.5 .. 239.5 cycles
`define HALF_000 9'h003
`define HALF_001 9'h00F
`define HALF_010 9'h01B
`define HALF_011 9'h039
`define HALF_100 9'h053
`define HALF_101 9'h06F
`define HALF_110 9'h08F
`define HALF_111 9'h1DF

`define REINIT_CYCLES 9'h008
`define CAL_CYCLES 9'h040
`define WAKE_CYCLES 9'h010

`endif

/* File: verilog/sample_len_decode.v */
// maps one channel number to its 3-bit sampling code and a half-cycle count
// assumes: both sampling-time registers are given whole, same clock domain
`timescale 1ns/10ps
`include "adc_ctl_regs.vh"

module sample_len_decode (
  input wire [31:0] spt_high,
  input wire [31:0] spt_low,
  input wire [4:0] channel,
  output reg [2:0] code,
  output reg [8:0] half_cycles
);

  integer ch;

  always @* begin
    ch = channel;
    code = spt_low[2:0];
    if (ch == `CH_EXTRA) begin
      code = spt_low[2:0];
    end else if (ch < `SPT_LO_FIELDS) begin
      code = spt_low[ch*`SPT_FIELD_W +: `SPT_FIELD_W];
    end else if (ch < `CH_HI_FIRST + `SPT_HI_FIELDS) begin
      code = spt_high[(ch-`CH_HI_FIRST)*`SPT_FIELD_W +: `SPT_FIELD_W];
    end
    case (code)
      3'h0: half_cycles = `HALF_000;
      3'h1: half_cycles = `HALF_001;
      3'h2: half_cycles = `HALF_010;
      3'h3: half_cycles = `HALF_011;
      3'h4: half_cycles = `HALF_100;
      3'h5: half_cycles = `HALF_101;
      3'h6: half_cycles = `HALF_110;
      default: half_cycles = `HALF_111;
    endcase
  end

endmodule // sample_len_decode

/* File: verilog/op_timer.v */
// down counter that times one hardware operation and pulses at its end
// assumes: start is a one-cycle pulse on clk
`timescale 1ns/10ps

module op_timer #(
  parameter W = 9
) (
  input wire clk,
  input wire nrst,
  input wire start,
  input wire [W-1:0] length,
  output wire busy,
  output reg done
);

  reg [W-1:0] count;

  assign busy = (count != {W{1'b0}});

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= {W{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= length;
      end else if (busy) begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
        if (count == {{(W-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end
      end
    end
  end

endmodule // op_timer

/* File: verilog/adc_sample_ctl.v */
// converter control: calibration bits, power-on, continuous mode and
// per-channel sampling time, reached over a classic Wishbone slave
// assumes: one clock, software uses whole-word accesses to these registers
`timescale 1ns/10ps
`include "adc_ctl_regs.vh"

// Notes on behaviour
// - writing one to cal_regs_reinit starts calibration register initialisation
// - hardware clears cal_regs_reinit once initialisation finishes
// - repeat_conversion one repeats conversions; zero disables continuous operation
// - converter wakes only on a zero-to-one change of converter_power_on
// - three-bit code picks sample length; 000 is 1.5, 111 is 239.5 cycles
// - codes 001, 010, 011 give 7.5, 13.5, 28.5 cycles
// - codes 100, 101, 110 give 41.5, 55.5, 71.5 cycles
// - channels 0 and 18 both use the lowest field of the low register
// - high register holds channels 10 to 17, three bits each from bit 0
// - low register holds channels 0 to 9, three bits each from bit 0
module adc_sample_ctl (
  input wire clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  input wire [4:0] convert_channel,
  input wire convert_done,
  output reg convert_start,
  output reg [8:0] convert_half_cycles,
  output reg converter_awake
);

  ////////////////////////////////////////////////////////////////////
  // register state

  reg cal_regs_reinit;
  reg calibrate_go;
  reg repeat_conversion;
  reg converter_power_on;
  reg [31:0] sample_time_high_channels;
  reg [31:0] sample_time_low_channels;
  reg waking;

  wire req;
  wire wr;
  wire full_word;
  wire [31:0] ctl1_now;
  wire [31:0] ctl1_new;
  wire reinit_busy;
  wire reinit_done;
  wire cal_busy;
  wire cal_done;
  wire wake_done;
  wire [8:0] cur_half;
  reg reinit_kick;
  reg cal_kick;
  reg wake_kick;
  reg soft_convert;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `CTL1_ADDR) || (a == `SPT_HI_ADDR) ||
                  (a == `SPT_LO_ADDR) || (a == `STATUS_ADDR);
    end
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr = req && wb_we_i && is_mapped(wb_adr_i);
  assign full_word = (wb_sel_i == 4'hF);

  assign ctl1_now = {28'h0000000, cal_regs_reinit, calibrate_go,
                     repeat_conversion, converter_power_on};
  assign ctl1_new = wb_dat_i & `CTL1_MASK;

  ////////////////////////////////////////////////////////////////////
  // bus slave: one wait-free answer, ack or err in the cycle after stb

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= `REG_RESET;
    end else begin
      wb_ack_o <= req && is_mapped(wb_adr_i);
      wb_err_o <= req && !is_mapped(wb_adr_i);
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `CTL1_ADDR: wb_dat_o <= ctl1_now;
          `SPT_HI_ADDR: wb_dat_o <= sample_time_high_channels;
          `SPT_LO_ADDR: wb_dat_o <= sample_time_low_channels;
          `STATUS_ADDR: wb_dat_o <= {30'h0000000, cal_busy | reinit_busy,
                                     converter_awake};
          default: wb_dat_o <= `REG_RESET;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register writes and hardware clears

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_regs_reinit <= 1'b0;
      calibrate_go <= 1'b0;
      repeat_conversion <= 1'b0;
      converter_power_on <= 1'b0;
      sample_time_high_channels <= `REG_RESET;
      sample_time_low_channels <= `REG_RESET;
      reinit_kick <= 1'b0;
      cal_kick <= 1'b0;
      wake_kick <= 1'b0;
      soft_convert <= 1'b0;
    end else begin
      reinit_kick <= 1'b0;
      cal_kick <= 1'b0;
      wake_kick <= 1'b0;
      soft_convert <= 1'b0;
      if (reinit_done) begin
        cal_regs_reinit <= 1'b0;
      end
      if (cal_done) begin
        calibrate_go <= 1'b0;
      end
      if (wr && wb_adr_i == `CTL1_ADDR && wb_sel_i[0]) begin
        repeat_conversion <= ctl1_new[`CTL1_REPEAT_BIT];
        converter_power_on <= ctl1_new[`CTL1_POWER_BIT];
        // a write of zero never aborts a running reinit or calibration; a zero power bit ends a wake
        if (ctl1_new[`CTL1_REINIT_BIT] && !cal_regs_reinit) begin
          cal_regs_reinit <= 1'b1;
          reinit_kick <= 1'b1;
        end
        if (ctl1_new[`CTL1_CAL_BIT] && !calibrate_go) begin
          calibrate_go <= 1'b1;
          cal_kick <= 1'b1;
        end
        if (ctl1_new[`CTL1_POWER_BIT] && !converter_power_on) begin
          wake_kick <= 1'b1;
        end
        if (converter_power_on && ctl1_new == ctl1_now) begin
          soft_convert <= 1'b1;
        end
      end
      // partial-lane writes dropped: these fields must change whole
      if (wr && full_word && wb_adr_i == `SPT_HI_ADDR) begin
        sample_time_high_channels <= wb_dat_i & `SPT_HI_MASK;
      end
      if (wr && full_word && wb_adr_i == `SPT_LO_ADDR) begin
        sample_time_low_channels <= wb_dat_i & `SPT_LO_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operation timers and converter sequencing

  op_timer #(.W(9)) reinit_timer (
    .clk(clk),
    .nrst(nrst),
    .start(reinit_kick),
    .length(`REINIT_CYCLES),
    .busy(reinit_busy),
    .done(reinit_done)
  );

  op_timer #(.W(9)) cal_timer (
    .clk(clk),
    .nrst(nrst),
    .start(cal_kick),
    .length(`CAL_CYCLES),
    .busy(cal_busy),
    .done(cal_done)
  );

  op_timer #(.W(9)) wake_timer (
    .clk(clk),
    .nrst(nrst),
    .start(wake_kick),
    .length(`WAKE_CYCLES),
    .busy(),
    .done(wake_done)
  );

  sample_len_decode decode (
    .spt_high(sample_time_high_channels),
    .spt_low(sample_time_low_channels),
    .channel(convert_channel),
    .code(),
    .half_cycles(cur_half)
  );

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      converter_awake <= 1'b0;
      waking <= 1'b0;
      convert_start <= 1'b0;
      convert_half_cycles <= `HALF_000;
    end else begin
      convert_start <= 1'b0;
      if (!converter_power_on) begin
        converter_awake <= 1'b0;
        waking <= 1'b0;
      end else if (wake_kick) begin
        waking <= 1'b1;
      end else if (waking && wake_done) begin
        waking <= 1'b0;
        converter_awake <= 1'b1;
      end
      // no conversions while waking or calibrating
      // power-on gate too: awake drops one cycle after power-off
      if (converter_power_on && converter_awake && !cal_busy && !reinit_busy &&
          (soft_convert || (repeat_conversion && convert_done))) begin
        convert_start <= 1'b1;
        convert_half_cycles <= cur_half;
      end
    end
  end

endmodule // adc_sample_ctl

/* File: verif/adc_sample_ctl_props.sv */
// assertions on the ports of the converter control block
// assumes: bound onto adc_sample_ctl, one clock clk, async reset nrst
`timescale 1ns/10ps
`include "adc_ctl_regs.vh"
module adc_sample_ctl_props (
  input wire clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire convert_start,
  input wire [8:0] convert_half_cycles,
  input wire converter_awake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hit = wb_adr_i inside {`CTL1_ADDR, `SPT_HI_ADDR, `SPT_LO_ADDR, `STATUS_ADDR};
  wire pw = req && wb_we_i && wb_adr_i == `CTL1_ADDR && wb_sel_i[0];
  //////////////////////////////
  property p_ack; req && hit |=> wb_ack_o && !wb_err_o; endproperty
  a_ack: assert property (p_ack) else $error("mapped access not acked");
  property p_err; req && !hit |=> wb_err_o && !wb_ack_o; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  property p_hold; !(req && !wb_we_i) |=> $stable(wb_dat_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  // wake takes time, so a fresh power-on must not show awake at once
  property p_wake;
    pw && wb_dat_i[0] && !converter_awake |=> !converter_awake [*8] ##[1:20] converter_awake;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up timing wrong");
  property p_off; pw && !wb_dat_i[0] |-> ##[1:2] !converter_awake; endproperty
  a_off: assert property (p_off) else $error("power off ignored");
  property p_len;
    convert_start |-> convert_half_cycles inside
      {9'h003, 9'h00F, 9'h01B, 9'h039, 9'h053, 9'h06F, 9'h08F, 9'h1DF};
  endproperty
  a_len: assert property (p_len) else $error("illegal sample length");
  property p_one; convert_start |=> !convert_start; endproperty
  a_one: assert property (p_one) else $error("start not a pulse");
  property p_run; convert_start |-> converter_awake; endproperty
  a_run: assert property (p_run) else $error("start while converter off");
  c_wake: cover property ($rose(converter_awake));
  c_start: cover property (convert_start);
  c_err: cover property (wb_err_o);
endmodule // adc_sample_ctl_props
bind adc_sample_ctl adc_sample_ctl_props i_adc_sample_ctl_props (.clk(clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .convert_start(convert_start),
  .convert_half_cycles(convert_half_cycles), .converter_awake(converter_awake));

/* File: verif/adc_sample_ctl_tb_top.sv */
// self-checking bench for the converter control block
// assumes: design and checker compiled first, Wishbone answers within a few cycles
`timescale 1ns/10ps
module adc_sample_ctl_tb_top;
  logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, cdone = 1'b0, e;
  logic [7:0] adr = 8'h00;
  logic [3:0] lanes = 4'hF;
  logic [31:0] dat = 32'h00000000, q, hi = 32'h00FAC688, lo = 32'h2D1B4E93;
  logic [4:0] ch = 5'h00;
  logic [2:0] c;
  wire [31:0] dat_o;
  wire ack, err, start, awake;
  wire [8:0] half;
  logic [8:0] tbl [8] = '{9'h003, 9'h00F, 9'h01B, 9'h039, 9'h053, 9'h06F, 9'h08F, 9'h1DF};
  int n_mismatch = 0, checks = 0, ncyc = 0;
  adc_sample_ctl i_adc_sample_ctl (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(lanes), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .convert_channel(ch), .convert_done(cdone),
    .convert_start(start), .convert_half_cycles(half), .converter_awake(awake));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    if (ncyc == 5000) begin
      n_mismatch++;
      test_done;
    end
  end
  //////////////////////////////
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  // entered just after a rising edge; ack is read before this edge's updates
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (!(ack === 1'b1 || err === 1'b1));
    q = dat_o;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h00000000);
    cmp(q, x);
  endtask
  task automatic wst(input logic x);
    e = 1'b0;
    // look before the first wait: a rewrite start stands at the edge acc returns on
    repeat (8) begin
      if (start === 1'b1 && !e) begin
        e = 1'b1;
        q = {23'h0, half};
      end
      @(posedge clk);
    end
    cmp({31'h00000000, e}, {31'h00000000, x});
  endtask
  task automatic pulse_done;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
  endtask
  //////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(8'h08, 32'h00000000);
    rd(8'h0C, 32'h00000000);
    rd(8'h10, 32'h00000000);
    acc(1'b1, 8'h0C, 32'h00FFFFFF);
    rd(8'h0C, 32'h00FFFFFF);
    acc(1'b1, 8'h10, 32'h3FFFFFFF);
    rd(8'h10, 32'h3FFFFFFF);
    // control write without lane 0 is acked but ignored, power stays off
    lanes <= 4'hE;
    acc(1'b1, 8'h08, 32'h00000001);
    lanes <= 4'hF;
    rd(8'h08, 32'h00000000);
    acc(1'b0, 8'h40, 32'h00000000);
    cmp({31'h00000000, e}, 32'h00000001);
    acc(1'b1, 8'h0C, hi);
    acc(1'b1, 8'h10, lo);
    acc(1'b1, 8'h08, 32'h00000001);
    repeat (20) @(posedge clk);
    rd(8'h14, 32'h00000001);
    for (int k = 0; k <= 18; k++) begin
      ch <= 5'(k);
      c = 3'(k < 10 ? lo >> (3 * k) : k < 18 ? hi >> (3 * (k - 10)) : lo);
      acc(1'b1, 8'h08, 32'h00000001);
      wst(1'b1);
      cmp(q, {23'h000000, tbl[c]});
    end
    acc(1'b1, 8'h08, 32'h00000003);
    repeat (8) @(posedge clk);
    pulse_done;
    wst(1'b1);
    acc(1'b1, 8'h08, 32'h00000001);
    repeat (8) @(posedge clk);
    pulse_done;
    wst(1'b0);
    acc(1'b1, 8'h08, 32'h00000005);
    rd(8'h08, 32'h00000005);
    repeat (70) @(posedge clk);
    rd(8'h08, 32'h00000001);
    acc(1'b1, 8'h08, 32'h00000009);
    rd(8'h08, 32'h00000009);
    repeat (10) @(posedge clk);
    rd(8'h08, 32'h00000001);
    acc(1'b1, 8'h08, 32'h00000000);
    rd(8'h14, 32'h00000000);
    test_done;
  end
endmodule // adc_sample_ctl_tb_top
